// file: rtl/rbcl_pkg.sv
// Purpose: Constants and types for the reset boot configuration latch
// Assumes: Pins are static and synchronous to clk while reset is held
// Notes:   Field positions are bit indices of the expansion data word
package rbcl_pkg;

  // ----------------------------------------
  // Word layout
  // ----------------------------------------
  localparam int RBCL_BOOT_LSB = 0;
  localparam int RBCL_BOOT_W = 5;
  localparam int RBCL_ENDIAN_BIT = 8;
  localparam int RBCL_FIFO_RD_BIT = 9;
  localparam int RBCL_ARB_BIT = 10;
  localparam int RBCL_HOST_BIT = 11;
  localparam int RBCL_RW_POL_BIT = 12;
  localparam int RBCL_BURST_POL_BIT = 13;
  localparam int RBCL_MEMTYPE0_LSB = 16;
  localparam int RBCL_MEMTYPE_STEP = 4;
  localparam int RBCL_MEMTYPE_W = 3;

  // ----------------------------------------
  // Codes and reset values
  // ----------------------------------------
  localparam logic [2:0] RBCL_MT_ASYNC = 3'h2;
  localparam logic [2:0] RBCL_MT_FIFO = 3'h5;
  localparam logic [4:0] RBCL_BOOT_RST = 5'h00;
  localparam logic [31:0] RBCL_WORD_RST = 32'h0000_0000;
  localparam logic [4:0] RBCL_CODE_HOST_EXT = 5'h06;
  localparam logic [4:0] RBCL_CODE_HOST_INT = 5'h07;
  localparam logic [2:0] RBCL_LOW_LAST = 3'h5;

  typedef enum logic [1:0] {RBCL_MAP0, RBCL_MAP1, RBCL_MAP_NONE} rbcl_map_t;
  typedef enum logic [2:0] {
    RBCL_MEM_SDRAM8, RBCL_MEM_SDRAM16, RBCL_MEM_ASYNC, RBCL_MEM_SBHALF,
    RBCL_MEM_SBFULL, RBCL_MEM_INTERNAL, RBCL_MEM_EXTDEF, RBCL_MEM_UNDEF
  } rbcl_mem_t;
  typedef enum logic [2:0] {
    RBCL_BOOT_NONE, RBCL_BOOT_HOST, RBCL_BOOT_ROM8, RBCL_BOOT_ROM16,
    RBCL_BOOT_ROM32
  } rbcl_boot_t;
  typedef enum logic [1:0] {
    RBCL_MEMTYPE_ASYNC, RBCL_MEMTYPE_FIFO, RBCL_MEMTYPE_RSVD
  } rbcl_memtype_t;

endpackage

// file: rtl/rbcl_cfg_if.sv
// Purpose: Carries the captured 5-bit boot code to the decoder
// Assumes: One clock domain
// Notes:   Capture side drives, decode side reads
`timescale 1ns/100ps
interface rbcl_cfg_if;
  logic [4:0] boot_code;
  modport src (output boot_code);
  modport dst (input boot_code);
endinterface

// file: rtl/rbcl_boot_decode.sv
// Purpose: Registered decode of the 5-bit boot code
// Assumes: Code is held stable after reset release
// Notes:   Outputs come from flip-flops
`timescale 1ns/100ps
module rbcl_boot_decode
  import rbcl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Captured code
  rbcl_cfg_if.dst cfg,
  // Decoded results
  output rbcl_map_t mem_map,
  output rbcl_mem_t addr0_memory,
  output rbcl_boot_t boot_process,
  output logic sdram_width_select
);

  rbcl_map_t next_map;
  rbcl_mem_t next_mem;
  rbcl_boot_t next_boot;
  logic [2:0] low;

  // ----------------------------------------
  // Code decode
  // ----------------------------------------
  always_comb begin
    low = cfg.boot_code[2:0];
    next_map = RBCL_MAP0;
    next_boot = RBCL_BOOT_NONE;
    case (low)
      3'h0: next_mem = RBCL_MEM_SDRAM8;
      3'h1: next_mem = RBCL_MEM_SDRAM16;
      3'h2: next_mem = RBCL_MEM_ASYNC;
      3'h3: next_mem = RBCL_MEM_SBHALF;
      3'h4: next_mem = RBCL_MEM_SBFULL;
      3'h5: begin
        next_mem = RBCL_MEM_INTERNAL;
        next_map = RBCL_MAP1;
      end
      3'h6: next_mem = RBCL_MEM_EXTDEF;
      default: begin
        next_mem = RBCL_MEM_INTERNAL;
        next_map = RBCL_MAP1;
      end
    endcase
    case (cfg.boot_code[4:3])
      2'h1: next_boot = RBCL_BOOT_ROM8;
      2'h2: next_boot = RBCL_BOOT_ROM16;
      2'h3: next_boot = RBCL_BOOT_ROM32;
      default: next_boot = RBCL_BOOT_NONE;
    endcase
    if (cfg.boot_code == RBCL_CODE_HOST_EXT ||
        cfg.boot_code == RBCL_CODE_HOST_INT) begin
      next_boot = RBCL_BOOT_HOST;
    end else if (low > RBCL_LOW_LAST) begin
      next_map = RBCL_MAP_NONE;
      next_mem = RBCL_MEM_UNDEF;
      next_boot = RBCL_BOOT_NONE;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_map <= RBCL_MAP0;
      addr0_memory <= RBCL_MEM_SDRAM8;
      boot_process <= RBCL_BOOT_NONE;
      sdram_width_select <= 1'b0;
    end else begin
      mem_map <= next_map;
      addr0_memory <= next_mem;
      boot_process <= next_boot;
      sdram_width_select <= (next_mem == RBCL_MEM_SDRAM16);
    end
  end

endmodule

// file: rtl/rbcl_latch.sv
// Purpose: Captures boot and device configuration pins during reset
// Assumes: Board resistors hold the pins static; pins synchronous to clk
// Notes:   Device reset is a synchronous input sampled on clk
`timescale 1ns/100ps
module rbcl_latch
  import rbcl_pkg::*;
#(
  parameter int CLK_MODE_W = 2,
  parameter bit EXP_VARIANT = 1'b1
) (
  // Clock and resets
  input wire logic clk,
  input wire logic nrst,
  input wire logic dev_reset_n,
  // Configuration pins
  input wire logic [4:0] boot_code_pins,
  input wire logic [CLK_MODE_W-1:0] clock_mode_pins,
  input wire logic endian_select_pin,
  input wire logic [31:0] expansion_data_lines,
  // Bus role
  input wire logic bus_initiator,
  // Boot decode
  output rbcl_map_t mem_map,
  output rbcl_mem_t addr0_memory,
  output rbcl_boot_t boot_process,
  output logic sdram_width_select,
  output logic [4:0] boot_code,
  // Clock and endian
  output logic [CLK_MODE_W-1:0] pll_mult_select,
  output logic little_endian,
  // Device configuration
  output rbcl_memtype_t memory_type_field [4],
  output logic burst_last_active_high,
  output logic read_write_polarity,
  output logic host_mode_select,
  output logic arbiter_enable_field,
  output logic arbiter_status,
  output logic fifo_read_mode,
  output logic [2:0] ext_mem_reset_select
);

  initial begin
    if (CLK_MODE_W < 1 || CLK_MODE_W > 8) begin
      $error("rbcl_latch: CLK_MODE_W out of range");
    end
  end

  logic [31:0] word;
  logic endian_cap;
  logic [CLK_MODE_W-1:0] clk_mode_cap;
  logic [4:0] boot_pin_cap;
  rbcl_cfg_if cfg ();

  // ----------------------------------------
  // Capture while device reset is held
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word <= RBCL_WORD_RST;
      endian_cap <= 1'b0;
      clk_mode_cap <= '0;
      boot_pin_cap <= RBCL_BOOT_RST;
    end else if (!dev_reset_n) begin
      word <= expansion_data_lines;
      endian_cap <= endian_select_pin;
      clk_mode_cap <= clock_mode_pins;
      boot_pin_cap <= boot_code_pins;
    end
  end

  // Held otherwise until next reset
  assign cfg.boot_code = EXP_VARIANT ?
    word[RBCL_BOOT_LSB +: RBCL_BOOT_W] : boot_pin_cap;

  rbcl_boot_decode u_dec (
    .clk(clk),
    .nrst(nrst),
    .cfg(cfg),
    .mem_map(mem_map),
    .addr0_memory(addr0_memory),
    .boot_process(boot_process),
    .sdram_width_select(sdram_width_select)
  );

  // ----------------------------------------
  // Memory type fields
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_mt
      logic [2:0] mt;
      assign mt = word[RBCL_MEMTYPE0_LSB + g*RBCL_MEMTYPE_STEP +:
        RBCL_MEMTYPE_W];
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          memory_type_field[g] <= RBCL_MEMTYPE_RSVD;
        end else if (mt == RBCL_MT_ASYNC) begin
          memory_type_field[g] <= RBCL_MEMTYPE_ASYNC;
        end else if (mt == RBCL_MT_FIFO) begin
          memory_type_field[g] <= RBCL_MEMTYPE_FIFO;
        end else begin
          memory_type_field[g] <= RBCL_MEMTYPE_RSVD;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Device fields and endian
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_code <= RBCL_BOOT_RST;
      pll_mult_select <= '0;
      little_endian <= 1'b0;
      burst_last_active_high <= 1'b0;
      read_write_polarity <= 1'b0;
      host_mode_select <= 1'b0;
      arbiter_enable_field <= 1'b0;
      arbiter_status <= 1'b0;
      fifo_read_mode <= 1'b0;
    end else begin
      boot_code <= cfg.boot_code;
      pll_mult_select <= clk_mode_cap;
      little_endian <= EXP_VARIANT ?
        word[RBCL_ENDIAN_BIT] : endian_cap;
      // Initiator always uses active low
      burst_last_active_high <= !bus_initiator &&
        word[RBCL_BURST_POL_BIT];
      read_write_polarity <= word[RBCL_RW_POL_BIT];
      host_mode_select <= word[RBCL_HOST_BIT];
      arbiter_enable_field <= word[RBCL_ARB_BIT];
      arbiter_status <= word[RBCL_ARB_BIT];
      fifo_read_mode <= word[RBCL_FIFO_RD_BIT];
    end
  end

  // ----------------------------------------
  // Memory interface reset selection
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_mem_reset_select <= 3'h0;
    end else begin
      ext_mem_reset_select <= cfg.boot_code[2:0];
    end
  end

endmodule

// file: sim/rbcl_board_model.sv
// Purpose: Board resistors on the configuration lines
// Assumes: Resistors are static, lines never float
// Notes: Bench picks the strap word
`timescale 1ns/100ps
module rbcl_board_model (
  // Strap word
  input wire logic [31:0] strap,
  // Lines
  output wire logic [31:0] lines
);
  assign lines = strap;
endmodule

// file: sim/rbcl_latch_assertions.sv
// Purpose: Port checks for the configuration latch
// Assumes: One clock, nrst asynchronous
// Notes: Bound into rbcl_latch
`timescale 1ns/100ps
module rbcl_latch_assertions
  import rbcl_pkg::*;
#(
  parameter int CLK_MODE_W = 2,
  parameter bit EXP_VARIANT = 1'b1
) (
  // Clock and resets
  input wire logic clk,
  input wire logic nrst,
  input wire logic dev_reset_n,
  // Inputs
  input wire logic [4:0] boot_code_pins,
  input wire logic endian_select_pin,
  input wire logic [CLK_MODE_W-1:0] clock_mode_pins,
  input wire logic [31:0] expansion_data_lines,
  input wire logic bus_initiator,
  // Outputs
  input rbcl_map_t mem_map,
  input rbcl_boot_t boot_process,
  input wire logic sdram_width_select,
  input wire logic [4:0] boot_code,
  input wire logic [CLK_MODE_W-1:0] pll_mult_select,
  input wire logic little_endian,
  input wire logic burst_last_active_high,
  input wire logic arbiter_status
);
  logic [4:0] src_code;
  logic src_end;
  // Pins that the variant captures
  assign src_code = EXP_VARIANT ?
    expansion_data_lines[4:0] : boot_code_pins;
  assign src_end = EXP_VARIANT ?
    expansion_data_lines[8] : endian_select_pin;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_code_capture: assert property (!dev_reset_n |-> ##2
    boot_code == $past(src_code, 2)) else $error("code");
  a_endian_capture: assert property (!dev_reset_n |-> ##2
    little_endian == $past(src_end, 2)) else $error("endian");
  a_pll_capture: assert property (!dev_reset_n |-> ##2
    pll_mult_select == $past(clock_mode_pins, 2)) else $error("pll");
  a_arb_status: assert property (!dev_reset_n |-> ##2
    arbiter_status == $past(expansion_data_lines[10], 2)) else $error("arb");
  a_width_decode: assert property (!dev_reset_n |-> ##2
    sdram_width_select == ($past(src_code[2:0], 2) == 3'h1))
    else $error("width");
  a_reserved_decode: assert property (!dev_reset_n &&
    src_code[2:1] == 2'h3 && src_code[4:3] != 2'h0
    |-> ##2 boot_process == RBCL_BOOT_NONE && mem_map == RBCL_MAP_NONE)
    else $error("reserved");
  a_blast_initiator: assert property (bus_initiator [*2] |->
    !burst_last_active_high) else $error("blast");
  a_hold_config: assert property (dev_reset_n [*4] |->
    $stable(boot_code) && $stable(mem_map) && $stable(little_endian))
    else $error("hold");
endmodule
bind rbcl_latch rbcl_latch_assertions #(
  .CLK_MODE_W(CLK_MODE_W),
  .EXP_VARIANT(EXP_VARIANT)
) u_chk (
  .clk, .nrst, .dev_reset_n, .boot_code_pins, .endian_select_pin,
  .clock_mode_pins, .expansion_data_lines,
  .bus_initiator, .mem_map, .boot_process, .sdram_width_select, .boot_code,
  .pll_mult_select, .little_endian, .burst_last_active_high,
  .arbiter_status);

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the configuration latch
// Assumes: Inputs change at the falling edge
// Notes: Expected values come from a table model
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import rbcl_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 0, nrst = 0, dev_reset_n = 0, end_pin = 0, bus_ini = 0;
  logic [4:0] code_pins = '0;
  logic [1:0] cm_pins = '0;
  logic [31:0] strap = '0, seed = 32'hb908;
  wire logic [31:0] lines;
  rbcl_map_t mem_map;
  rbcl_mem_t addr0;
  rbcl_boot_t boot;
  rbcl_memtype_t mtf [4];
  logic sdw, lit_end, bl_hi, rwp, hms, aef, ast, frm, p_end;
  logic [4:0] code, p_code;
  logic [1:0] pll;
  logic [2:0] ers;
  int bad_count = 0, n_compared = 0;
  initial forever #4 clk = ~clk;
  rbcl_board_model u_board (.strap(strap), .lines(lines));
  rbcl_latch #(.CLK_MODE_W(2), .EXP_VARIANT(1'b1)) u_dut (.clk(clk),
    .nrst(nrst), .dev_reset_n(dev_reset_n), .boot_code_pins(code_pins),
    .clock_mode_pins(cm_pins), .endian_select_pin(end_pin),
    .expansion_data_lines(lines), .bus_initiator(bus_ini),
    .mem_map(mem_map), .addr0_memory(addr0), .boot_process(boot),
    .sdram_width_select(sdw), .boot_code(code), .pll_mult_select(pll),
    .little_endian(lit_end), .memory_type_field(mtf),
    .burst_last_active_high(bl_hi), .read_write_polarity(rwp),
    .host_mode_select(hms), .arbiter_enable_field(aef),
    .arbiter_status(ast), .fifo_read_mode(frm),
    .ext_mem_reset_select(ers));
  // Dedicated pin variant
  rbcl_latch #(.CLK_MODE_W(2), .EXP_VARIANT(1'b0)) u_pin (.clk(clk),
    .nrst(nrst), .dev_reset_n(dev_reset_n), .boot_code_pins(code_pins),
    .clock_mode_pins(cm_pins), .endian_select_pin(end_pin),
    .expansion_data_lines(lines), .bus_initiator(bus_ini), .mem_map(),
    .addr0_memory(), .boot_process(), .sdram_width_select(),
    .boot_code(p_code), .pll_mult_select(), .little_endian(p_end),
    .memory_type_field(), .burst_last_active_high(),
    .read_write_polarity(), .host_mode_select(), .arbiter_enable_field(),
    .arbiter_status(), .fifo_read_mode(), .ext_mem_reset_select());
  // ----------------------------------------
  // Model and tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) s = {s[30:0], s[31]^s[21]^s[1]^s[0]};
    return s;
  endfunction
  function automatic rbcl_memtype_t mt(input logic [2:0] v);
    return v == 3'h2 ? RBCL_MEMTYPE_ASYNC :
      v == 3'h5 ? RBCL_MEMTYPE_FIFO : RBCL_MEMTYPE_RSVD;
  endfunction
  task automatic check(input logic [31:0] w, input logic [1:0] cm);
    rbcl_mem_t tab [6] = '{RBCL_MEM_SDRAM8, RBCL_MEM_SDRAM16, RBCL_MEM_ASYNC,
      RBCL_MEM_SBHALF, RBCL_MEM_SBFULL, RBCL_MEM_INTERNAL};
    rbcl_boot_t bt [4] = '{RBCL_BOOT_NONE, RBCL_BOOT_ROM8, RBCL_BOOT_ROM16,
      RBCL_BOOT_ROM32};
    int lo = w[2:0];
    int hi = w[4:3];
    rbcl_map_t em = (lo == 5 || lo == 7) ? RBCL_MAP1 : RBCL_MAP0;
    rbcl_mem_t ea = lo == 6 ? RBCL_MEM_EXTDEF :
      lo == 7 ? RBCL_MEM_INTERNAL : tab[lo];
    rbcl_boot_t eb = lo > 5 ? RBCL_BOOT_HOST : bt[hi];
    if (lo > 5 && hi != 0) begin
      em = RBCL_MAP_NONE;
      ea = RBCL_MEM_UNDEF;
      eb = RBCL_BOOT_NONE;
    end
    `CHK("map", em, mem_map)
    `CHK("mem0", ea, addr0)
    `CHK("boot", eb, boot)
    `CHK("sdw", lo == 1, sdw)
    `CHK("code", w[4:0], code)
    `CHK("extmem", w[2:0], ers)
    `CHK("pll", cm, pll)
    `CHK("endian", w[8], lit_end)
    `CHK("blast pol", w[13] & ~bus_ini, bl_hi)
    `CHK("fields", w[12:9], {rwp, hms, aef, frm})
    `CHK("arb", w[10], ast)
    for (int i = 0; i < 4; i++) `CHK("memtype", mt(w[16+4*i +: 3]), mtf[i])
  endtask
  task automatic run(input logic [31:0] w);
    logic [1:0] cm;
    logic [4:0] cp;
    logic ep;
    seed = lfsr(seed);
    cm = seed[1:0];
    cp = seed[7:3];
    ep = seed[8];
    @(negedge clk);
    strap = w;
    cm_pins = cm;
    bus_ini = seed[2];
    code_pins = cp;
    end_pin = ep;
    dev_reset_n = 0;
    repeat (2) @(negedge clk);
    dev_reset_n = 1;
    repeat (4) @(negedge clk);
    check(w, cm);
    `CHK("pin code", cp, p_code)
    `CHK("pin endian", ep, p_end)
    strap = ~w;
    cm_pins = ~cm;
    code_pins = ~cp;
    end_pin = ~ep;
    repeat (4) @(negedge clk);
    check(w, cm);
    `CHK("pin hold", {ep, cp}, {p_end, p_code})
    $display("test %0h done", w[4:0]);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1;
    for (int c = 0; c < 32; c++) begin
      seed = lfsr(seed);
      run({seed[31:5], c[4:0]});
    end
    nrst = 0;
    @(negedge clk);
    `CHK("rst map", RBCL_MAP0, mem_map)
    `CHK("rst code", 5'h00, code)
    `CHK("rst memtype", RBCL_MEMTYPE_RSVD, mtf[0])
    nrst = 1;
    run(32'h2525_3f19);
    final_report;
  end
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    final_report;
  end
endmodule
